// ### design/upfsm_top.sv
// top of the usb port fault and status monitor with its apb registers
//------------------------------------------------------------
// Functional notes
// - drive fault low while thermal, overcurrent or data overvoltage fault holds
// - overcurrent fault asserts and releases after 8 ms of persistence
// - no overcurrent fault in either low-limit mode
// - data-line overvoltage opens data switches at once
// - overvoltage fault after 16 ms, released at once on clearing
// - overtemperature opens power and data switches, fault without delay
// - limited trip while current limiting, unlimited trip otherwise
// - switches stay off until die cools by the hysteresis
// - cable compensation sink is 75 uA per ampere of load
// - discharge sequence: power off, discharge output, power on again
// - data-line discharge path on while overvoltage protection holds
// - on overvoltage removal reclose data switch, drop discharge path
// - high limit in charging modes, low limit in non-charging modes
// - status flag set in charging modes after load above set level for 210 ms
// - status flag released after load below clear level for 3 s
// - flag set interval within 120..280 ms, release within 1.8..4.2 s
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "upfsm_consts.svh"

module upfsm_top #(
   parameter int unsigned OC_DG_CYC  = `UPF_OC_DG_CYC,
   parameter int unsigned OV_DG_CYC  = `UPF_OV_DG_CYC,
   parameter int unsigned LD_SET_CYC = `UPF_LD_SET_CYC,
   parameter int unsigned LD_CLR_CYC = `UPF_LD_CLR_CYC,
   parameter int unsigned DCHG_CYC   = `UPF_DCHG_CYC
) (
   input  wire logic                      mclk_in,
   input  wire logic                      resetn_in,
   input  wire logic                      psel_in,
   input  wire logic                      penable_in,
   input  wire logic                      pwrite_in,
   input  wire logic [7:0]                paddr_in,
   input  wire logic [31:0]               pwdata_in,
   output logic      [31:0]               prdata_out,
   output logic                           pready_out,
   output logic                           pslverr_out,
   input  wire upfsm_pkg::upfsm_sense_s   sense_in,
   output upfsm_pkg::upfsm_sw_s           switch_out,
   output logic                           fault_n_out,
   output logic                           fault_n_oe_out,
   output logic                           status_n_out,
   output logic                           status_n_oe_out,
   output logic      [8:0]                cs_sink_ua_out,
   output logic                           irq_out
);

   localparam int CW = `UPF_CNT_W;
   localparam logic [CW-1:0] OC_LIM   = CW'(OC_DG_CYC);
   localparam logic [CW-1:0] OV_LIM   = CW'(OV_DG_CYC);
   localparam logic [CW-1:0] SET_LIM  = CW'(LD_SET_CYC);
   localparam logic [CW-1:0] CLR_LIM  = CW'(LD_CLR_CYC);
   localparam logic [CW-1:0] DCHG_LIM = CW'(DCHG_CYC);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   upfsm_pkg::upfsm_mode_e mode;
   upfsm_pkg::upfsm_mode_e next_mode;
   upfsm_pkg::upfsm_evt_s  irq_stat;
   upfsm_pkg::upfsm_evt_s  next_irq_stat;
   upfsm_pkg::upfsm_evt_s  irq_mask;
   upfsm_pkg::upfsm_evt_s  next_irq_mask;
   upfsm_pkg::upfsm_evt_s  evt;
   upfsm_pkg::upfsm_sw_s   next_sw;
   logic [31:0]            next_prdata;
   logic                   next_pready;
   logic                   next_pslverr;
   logic                   next_irq;
   logic                   dchg_go;
   logic                   next_dchg_go;
   logic                   therm_sd;
   logic                   next_therm_sd;
   logic                   oc_flt;
   logic                   next_oc_flt;
   logic                   ov_flt;
   logic                   next_ov_flt;
   logic                   next_ld_flag;
   logic                   next_fault;
   logic [8:0]             next_cs;
   logic                   acc;
   logic                   wr;
   logic                   ov;
   logic                   trip;
   logic                   low_mode;
   logic                   charging;
   logic                   ld_flag;
   logic                   fault;
   logic                   oc_on_hit;
   logic                   oc_off_hit;
   logic                   ov_hit;
   logic                   ld_on_hit;
   logic                   ld_off_hit;
   logic                   dchg_act;

   //------------------------------------------------------------
   // condition decode
   //------------------------------------------------------------
   assign ov       = sense_in.data_plus_line_ov | sense_in.data_minus_line_ov;
   assign low_mode = (mode == upfsm_pkg::LOW_LIMIT_DATA_PORT_MODE) ||
                     (mode == upfsm_pkg::LOW_LIMIT_CHARGE_ONLY_MODE);
   assign charging = !low_mode;
   assign ld_flag  = status_n_oe_out;
   assign fault    = fault_n_oe_out;

   // the trip point follows whether the switch is limiting
   assign trip = sense_in.current_limiting ? sense_in.over_thermal_trip_limited
                                           : sense_in.over_thermal_trip_unlimited;

   //------------------------------------------------------------
   // persistence timers
   //------------------------------------------------------------
   // overcurrent must persist both ways before the flag moves
   upfsm_persist #(.W(CW)) u_oc_on (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .cond_in   (sense_in.current_limiting),
      .limit_in  (OC_LIM),
      .hit_out   (oc_on_hit)
   );

   upfsm_persist #(.W(CW)) u_oc_off (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .cond_in   (!sense_in.current_limiting),
      .limit_in  (OC_LIM),
      .hit_out   (oc_off_hit)
   );

   // only the assertion of the overvoltage fault is deglitched
   upfsm_persist #(.W(CW)) u_ov_on (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .cond_in   (ov),
      .limit_in  (OV_LIM),
      .hit_out   (ov_hit)
   );

   // 210 ms default sits inside the 120..280 ms window
   upfsm_persist #(.W(CW)) u_ld_on (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .cond_in   (sense_in.load_above_set),
      .limit_in  (SET_LIM),
      .hit_out   (ld_on_hit)
   );

   // 3 s default sits inside the 1.8..4.2 s window
   upfsm_persist #(.W(CW)) u_ld_off (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .cond_in   (sense_in.load_below_clear),
      .limit_in  (CLR_LIM),
      .hit_out   (ld_off_hit)
   );

   upfsm_discharge #(.W(CW)) u_dchg (
      .mclk_in    (mclk_in),
      .resetn_in  (resetn_in),
      .start_in   (dchg_go),
      .hold_in    (DCHG_LIM),
      .active_out (dchg_act)
   );

   //------------------------------------------------------------
   // protection and status flags
   //------------------------------------------------------------
   // outputs are built from next values so each reacts one edge after its cause
   always_comb begin
      next_therm_sd = therm_sd;
      if (trip) begin
         next_therm_sd = 1'b1;
      end else if (sense_in.temp_cooled) begin
         next_therm_sd = 1'b0;                 // cycles back on after cooling
      end
      next_oc_flt = oc_flt;
      if (oc_on_hit) begin
         next_oc_flt = 1'b1;
      end else if (oc_off_hit) begin
         next_oc_flt = 1'b0;
      end
      next_ov_flt = ov && (ov_flt || ov_hit);
      // a non-charging port never holds the load flag
      next_ld_flag = ld_flag;
      if (!charging) begin
         next_ld_flag = 1'b0;
      end else if (ld_on_hit) begin
         next_ld_flag = 1'b1;
      end else if (ld_off_hit) begin
         next_ld_flag = 1'b0;
      end
      // overcurrent is masked in low-limit modes
      next_fault = next_therm_sd | next_ov_flt | (next_oc_flt & charging);
      next_sw.power_on  = !next_therm_sd && !dchg_act;
      next_sw.data_on   = !next_therm_sd && !ov;
      next_sw.out_dchg  = dchg_act;
      next_sw.data_dchg = ov;
      next_sw.high_current_limit_setting = charging;
      // truncation of the sub-microampere part is accepted
      next_cs = 9'((({10'h000, sense_in.load_ma}) * `UPF_CS_GAIN) / `UPF_CS_MA_PER_A);
      evt.fault    = next_fault & !fault;
      evt.ov       = ov & !switch_out.data_dchg;
      evt.thermal  = next_therm_sd & !therm_sd;
      evt.ld_set   = next_ld_flag & !ld_flag;
      evt.ld_clear = !next_ld_flag & ld_flag;
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         therm_sd        <= 1'b0;
         oc_flt          <= 1'b0;
         ov_flt          <= 1'b0;
         switch_out      <= '0;
         fault_n_oe_out  <= 1'b0;
         fault_n_out     <= 1'b1;
         status_n_oe_out <= 1'b0;
         status_n_out    <= 1'b1;
         cs_sink_ua_out  <= 9'h000;
      end else begin
         therm_sd        <= next_therm_sd;
         oc_flt          <= next_oc_flt;
         ov_flt          <= next_ov_flt;
         switch_out      <= next_sw;
         fault_n_oe_out  <= next_fault;        // open drain pulls low while set
         fault_n_out     <= ~next_fault;
         status_n_oe_out <= next_ld_flag;
         status_n_out    <= ~next_ld_flag;
         cs_sink_ua_out  <= next_cs;
      end
   end

   //------------------------------------------------------------
   // apb slave and interrupt registers
   //------------------------------------------------------------
   // one wait state keeps prdata and pready straight from flops
   always_comb begin
      acc           = psel_in && penable_in;
      wr            = acc && pready_out && pwrite_in;
      next_pready   = acc && !pready_out;
      next_prdata   = prdata_out;
      next_pslverr  = 1'b0;
      next_mode     = mode;
      next_dchg_go  = 1'b0;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (acc && !pready_out) begin
         next_prdata = 32'h0000_0000;
         case (paddr_in)
            `UPF_ADDR_CTRL:  next_prdata = {30'h0, mode};
            `UPF_ADDR_STAT:  next_prdata = {26'h0, dchg_act, ld_flag, oc_flt,
                                            ov_flt, therm_sd, fault};
            `UPF_ADDR_ISTAT: next_prdata = {27'h0, irq_stat};
            `UPF_ADDR_IMASK: next_prdata = {27'h0, irq_mask};
            default:         next_pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr_in)
            `UPF_ADDR_CTRL: begin
               next_mode    = upfsm_pkg::upfsm_mode_e'(pwdata_in[1:0]);
               next_dchg_go = pwdata_in[`UPF_CTRL_DCHG_BIT];
            end
            `UPF_ADDR_ISTAT: begin
               next_irq_stat = upfsm_pkg::upfsm_evt_s'(irq_stat & ~pwdata_in[4:0]);
            end
            `UPF_ADDR_IMASK: begin
               next_irq_mask = upfsm_pkg::upfsm_evt_s'(pwdata_in[4:0]);
            end
            default: ;
         endcase
      end
      // a new event beats a clear written in the same cycle
      next_irq_stat = upfsm_pkg::upfsm_evt_s'(next_irq_stat | evt);
      next_irq      = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         mode        <= upfsm_pkg::upfsm_mode_e'(`UPF_MODE_RST);
         dchg_go     <= 1'b0;
         irq_stat    <= '0;
         irq_mask    <= upfsm_pkg::upfsm_evt_s'(`UPF_IMASK_RST);
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         irq_out     <= 1'b0;
      end else begin
         mode        <= next_mode;
         dchg_go     <= next_dchg_go;
         irq_stat    <= next_irq_stat;
         irq_mask    <= next_irq_mask;
         prdata_out  <= next_prdata;
         pready_out  <= next_pready;
         pslverr_out <= next_pslverr;
         irq_out     <= next_irq;
      end
   end

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   a_fault_level:
      assert property (1'b1 |=> fault_n_oe_out ==
                       (therm_sd | ov_flt | (oc_flt & !$past(low_mode))))
      else $error("fault pin does not follow the fault sources");

   a_oc_hold_flag:
      assert property (oc_flt && sense_in.current_limiting |=> oc_flt ##0
                       !(!sense_in.current_limiting && !oc_flt) or oc_flt)
      else $error("overcurrent fault dropped while limiting");

   a_oc_low_mask:
      assert property (low_mode && !next_therm_sd && !next_ov_flt |=> !fault_n_oe_out)
      else $error("overcurrent reported in a low-limit mode");

   a_ov_data_open:
      assert property (ov |=> !switch_out.data_on)
      else $error("data switch still closed during overvoltage");

   a_ov_release:
      assert property (!ov |=> !ov_flt)
      else $error("overvoltage fault held after clearing");

   a_thermal_off:
      assert property (trip |=> !switch_out.power_on && !switch_out.data_on && fault_n_oe_out)
      else $error("thermal trip did not shut down");

   a_thermal_hold:
      assert property (therm_sd && !trip && !sense_in.temp_cooled |=> therm_sd &&
                       !switch_out.power_on)
      else $error("switches restored before cooling");

   a_dchg_path:
      assert property (1'b1 |=> switch_out.data_dchg == $past(ov))
      else $error("data discharge path does not follow overvoltage");

   a_ov_reclose:
      assert property ($fell(ov) && !next_therm_sd |=> switch_out.data_on)
      else $error("data switch not reclosed after overvoltage");

   a_out_dchg_off:
      assert property (switch_out.out_dchg |-> !switch_out.power_on)
      else $error("power switch on during output discharge");

   a_ld_charging:
      assert property (!charging |=> !status_n_oe_out && status_n_out)
      else $error("load flag set in a non-charging mode");

   a_irq_set_wins:
      assert property (evt.fault |=> irq_stat.fault)
      else $error("fault event lost in interrupt status");

endmodule
`default_nettype wire

// ### design/upfsm_consts.svh
// constants of the usb port fault and status monitor
`ifndef UPFSM_CONSTS_SVH
`define UPFSM_CONSTS_SVH

//------------------------------------------------------------
// clock and timing
//------------------------------------------------------------
`define UPF_CLK_HZ          200000000
`define UPF_OC_DG_MS        8
`define UPF_OV_DG_MS        16
`define UPF_LD_SET_MS       210
`define UPF_LD_SET_MIN_MS   120
`define UPF_LD_SET_MAX_MS   280
`define UPF_LD_CLR_S        3
`define UPF_DCHG_MS         320
`define UPF_OC_DG_CYC       (`UPF_OC_DG_MS * (`UPF_CLK_HZ / 1000))
`define UPF_OV_DG_CYC       (`UPF_OV_DG_MS * (`UPF_CLK_HZ / 1000))
`define UPF_LD_SET_CYC      (`UPF_LD_SET_MS * (`UPF_CLK_HZ / 1000))
`define UPF_LD_CLR_CYC      (`UPF_LD_CLR_S * `UPF_CLK_HZ)
`define UPF_DCHG_CYC        (`UPF_DCHG_MS * (`UPF_CLK_HZ / 1000))
`define UPF_CNT_W           30

//------------------------------------------------------------
// cable compensation gain, microamperes per ampere
//------------------------------------------------------------
`define UPF_CS_GAIN         22'd75
`define UPF_CS_MA_PER_A     22'd1000

//------------------------------------------------------------
// register map and fields
//------------------------------------------------------------
`define UPF_ADDR_CTRL       8'h00
`define UPF_ADDR_STAT       8'h04
`define UPF_ADDR_ISTAT      8'h08
`define UPF_ADDR_IMASK      8'h0c
`define UPF_CTRL_DCHG_BIT   2
`define UPF_IRQ_W           5
`define UPF_MODE_RST        2'h0
`define UPF_IMASK_RST       5'h00

`endif

// ### design/upfsm_pkg.sv
// types of the usb port fault and status monitor
package upfsm_pkg;

   // port modes: two charging modes on the high limit, two on the low limit
   typedef enum logic [1:0] {
      MODE_CHARGE_DATA          = 2'b00,
      MODE_CHARGE_ONLY          = 2'b01,
      LOW_LIMIT_DATA_PORT_MODE  = 2'b10,
      LOW_LIMIT_CHARGE_ONLY_MODE = 2'b11
   } upfsm_mode_e;

   typedef enum logic {
      DCHG_IDLE   = 1'b0,
      DCHG_ACTIVE = 1'b1
   } upfsm_dchg_e;

   // comparator and sense inputs from the analog side
   typedef struct packed {
      logic        current_limiting;
      logic        data_plus_line_ov;
      logic        data_minus_line_ov;
      logic        over_thermal_trip_limited;
      logic        over_thermal_trip_unlimited;
      logic        temp_cooled;
      logic        load_above_set;
      logic        load_below_clear;
      logic [11:0] load_ma;
   } upfsm_sense_s;

   // switch and discharge controls to the analog side
   typedef struct packed {
      logic power_on;
      logic data_on;
      logic out_dchg;
      logic data_dchg;
      logic high_current_limit_setting;
   } upfsm_sw_s;

   // event layout shared by interrupt status and mask
   typedef struct packed {
      logic ld_clear;
      logic ld_set;
      logic thermal;
      logic ov;
      logic fault;
   } upfsm_evt_s;

endpackage

// ### design/upfsm_persist.sv
// persistence timer: flags a condition held for a set number of cycles
`timescale 1ns/1ps
`default_nettype none

module upfsm_persist #(
   parameter int W = 30
) (
   input  wire logic         mclk_in,
   input  wire logic         resetn_in,
   input  wire logic         cond_in,
   input  wire logic [W-1:0] limit_in,
   output logic              hit_out
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic [W-1:0] last;

   //------------------------------------------------------------
   // counter
   //------------------------------------------------------------
   // restarts from zero when the condition drops out
   always_comb begin
      last     = W'(limit_in - 1'b1);
      next_cnt = '0;
      if (cond_in && cnt != last) begin
         next_cnt = W'(cnt + 1'b1);
      end else if (cond_in) begin
         next_cnt = cnt;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // high in the cycle that completes limit_in cycles of the condition
   assign hit_out = cond_in && (cnt == last);

endmodule
`default_nettype wire

// ### design/upfsm_discharge.sv
// output discharge sequencer: switch off, discharge, then restore
`timescale 1ns/1ps
`default_nettype none

module upfsm_discharge #(
   parameter int W = 30
) (
   input  wire logic         mclk_in,
   input  wire logic         resetn_in,
   input  wire logic         start_in,
   input  wire logic [W-1:0] hold_in,
   output logic              active_out
);

   upfsm_pkg::upfsm_dchg_e state;
   upfsm_pkg::upfsm_dchg_e next_state;
   logic [W-1:0]           cnt;
   logic [W-1:0]           next_cnt;

   //------------------------------------------------------------
   // sequence
   //------------------------------------------------------------
   // a start during discharge is ignored, the hold time is not stretched
   always_comb begin
      next_state = state;
      next_cnt   = '0;
      unique case (state)
         upfsm_pkg::DCHG_IDLE: begin
            if (start_in) begin
               next_state = upfsm_pkg::DCHG_ACTIVE;
            end
         end
         upfsm_pkg::DCHG_ACTIVE: begin
            next_cnt = W'(cnt + 1'b1);
            if (cnt == W'(hold_in - 1'b1)) begin
               next_state = upfsm_pkg::DCHG_IDLE; // restore output
               next_cnt   = '0;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state <= upfsm_pkg::DCHG_IDLE;
         cnt   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   assign active_out = (state == upfsm_pkg::DCHG_ACTIVE);

endmodule
`default_nettype wire

// ### test/upfsm_ppm_model.sv
// power manager model that moves the other ports to the low limit
`timescale 1ns/1ps
`default_nettype none

module upfsm_ppm_model #(
   parameter int ALLOWED = 1
) (
   input  wire logic       mclk_in,
   input  wire logic       resetn_in,
   input  wire logic [1:0] flag_in,
   output logic      [1:0] force_low_out
);
   //------------------------------------------------------------
   // port allocation
   //------------------------------------------------------------
   // one cycle late on purpose: a real manager polls the flags
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         force_low_out <= 2'h0;
      end else if ($countones(flag_in) >= ALLOWED) begin
         force_low_out <= ~flag_in;
      end else begin
         force_low_out <= 2'h0;
      end
   end
endmodule

`default_nettype wire

// ### test/upfsm_top_tb.sv
// self-checking testbench of the usb port fault and status monitor
`timescale 1ns/1ps
`default_nettype none

module upfsm_top_tb;
   typedef struct {
      logic [19:0] s;
      int          n;
      logic [4:0]  sw;
      logic        f;
      logic [8:0]  cs;
   } upfsm_row_s;
   localparam logic [19:0] sense_idle = 20'h04000; // die cool, no events
   localparam logic [19:0] sense_lim  = 20'h84000; // switch in current limit
   logic                 mclk_in    = 1'b0;
   logic                 resetn_in  = 1'b0;
   logic                 psel       = 1'b0;
   logic                 penable    = 1'b0;
   logic                 pwrite     = 1'b0;
   logic [7:0]           paddr      = 8'h00;
   logic [31:0]          pwdata     = 32'h0;
   logic [19:0]          sense      = sense_idle;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   upfsm_pkg::upfsm_sw_s sw;
   logic                 fault_n;
   logic                 status_n;
   logic                 status_oe;
   logic                 fault_oe;
   logic                 other_flag = 1'b0; // status flag of the neighbouring port
   logic [8:0]           cs;
   logic                 irq;
   logic [1:0]           force_low;
   logic [31:0]          rd;
   logic                 er;
   int                   n;
   int                   mismatches = 0;
   int                   cmp_count  = 0;
   // sense pattern, cycles held, switches, fault pin, sink current
   upfsm_row_s rows[7] = '{'{20'h083e8, 2, 5'h01, 1'b0, 9'd75},
      '{20'h90fff, 2, 5'h01, 1'b0, 9'd307}, '{20'h10000, 2, 5'h19, 1'b1, 9'd0},
      '{20'h40000, 2, 5'h13, 1'b1, 9'd0}, '{20'h20000, 20, 5'h13, 1'b0, 9'd0},
      '{20'h80000, 4, 5'h19, 1'b1, 9'd0}, '{20'h80000, 12, 5'h19, 1'b0, 9'd0}};

   always #2.5 mclk_in = ~mclk_in;

   upfsm_top #(.OC_DG_CYC(8), .OV_DG_CYC(16), .LD_SET_CYC(21), .LD_CLR_CYC(30),
      .DCHG_CYC(10)) dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .sense_in(upfsm_pkg::upfsm_sense_s'(sense)), .switch_out(sw),
      .fault_n_out(fault_n), .fault_n_oe_out(fault_oe), .status_n_out(status_n),
      .status_n_oe_out(status_oe), .cs_sink_ua_out(cs), .irq_out(irq));

   upfsm_ppm_model ppm_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .flag_in({other_flag, status_oe}), .force_low_out(force_low));

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_in);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // apb master: holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk_in);
      penable <= 1'b1;
      // no wait-state count assumed: only the watchdog ends a hung transfer
      do begin
         @(posedge mclk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   //------------------------------------------------------------
   // tests
   //------------------------------------------------------------
   initial begin
      cyc(5);
      resetn_in <= 1'b1;
      foreach (rows[i]) begin
         sense <= rows[i].s;
         cyc(rows[i].n);
         chk(sw, rows[i].sw);
         chk(fault_n, rows[i].f);
         chk(fault_oe, !rows[i].f);
         chk(cs, rows[i].cs);
         sense <= sense_idle;
         cyc(12);
         chk(sw, 5'h19);
         chk(fault_n, 1'b1);
         $display("row %0d done", i);
      end
      // a one-cycle dropout must restart the overcurrent timer
      sense <= sense_lim;
      cyc(6);
      sense <= sense_idle;
      cyc(1);
      sense <= sense_lim;
      cyc(6);
      chk(fault_n, 1'b1);
      $display("dropout test done");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 8'h00, m);
         sense <= sense_lim;
         cyc(12);
         chk(sw.high_current_limit_setting, m < 2);
         chk(fault_n, m > 1);
         apb(1'b0, 8'h00, 32'h0);
         chk(rd, m);
         sense <= sense_idle;
         cyc(12);
      end
      $display("mode test done");
      apb(1'b1, 8'h00, 32'h0);
      chk(irq, 1'b0); // events were pending but masked
      apb(1'b1, 8'h08, 32'h1f);
      apb(1'b1, 8'h0c, 32'h08);
      sense <= 20'h06000;
      cyc(15);
      chk(status_n, 1'b1);
      cyc(10);
      chk({status_n, status_oe, irq, force_low}, 5'b01110);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd[3], 1'b1); // sticky event bit
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h10);
      apb(1'b1, 8'h08, 32'h08);
      cyc(2);
      chk(irq, 1'b0); // writing one clears it
      sense <= 20'h05000;
      cyc(20);
      chk(status_n, 1'b0);
      cyc(15);
      chk({status_n, status_oe, force_low}, 4'b1000);
      // the neighbour takes the only high-limit slot, so this port is pushed down
      other_flag <= 1'b1;
      cyc(3);
      chk(force_low, 2'b01);
      other_flag <= 1'b0;
      cyc(3);
      chk(force_low, 2'b00);
      $display("load test done");
      sense <= sense_idle;
      apb(1'b1, 8'h00, 32'h04);
      n = 0;
      while (sw.power_on === 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      chk(sw.out_dchg, 1'b1);
      n = 0;
      while (sw.power_on !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      chk(n inside {[9:11]}, 1'b1);
      chk(sw.out_dchg, 1'b0);
      $display("discharge test done");
      apb(1'b0, 8'h10, 32'h0);
      chk(er, 1'b1); // unmapped address is refused
      chk(rd, 32'h0);
      // reset in mid-run during a thermal trip
      sense <= 20'h08000;
      cyc(3);
      // trip gone but die not yet cooled: switches must stay open
      sense <= 20'h00000;
      cyc(3);
      chk({sw, fault_n}, 6'h02);
      resetn_in <= 1'b0;
      cyc(2);
      chk({sw, fault_n}, 6'h01);
      resetn_in <= 1'b1;
      sense <= sense_idle;
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      chk(sw, 5'h19);
      $display("reset test done");
      end_of_test;
   end

   // cut a hang short well beyond the few hundred cycles the tests take
   initial begin
      #20000;
      mismatches++;
      end_of_test;
   end
endmodule

`default_nettype wire
